// File: hw/rvsp_top.sv
// What this block does
// - Steps are spaced so the rate never exceeds 8500 steps per second.
// - Attenuation quantum 0.01/0.02/0.05/0.1 dB over 0-21/21-30/30-48/48-60 dB.
// - Over-range attenuation with high attenuation off runs the reset procedure.
// - Over-range attenuation with high attenuation on moves to maximum attenuation.
// - Settings finer than the quantum round to the nearest reachable value.
// - Step-count mode accepts targets only from -150 to 8574 steps.
// - Steps map to dB by 40 log sec of (8574-steps)*0.72/70 degrees.
// - Coarse position input enables the reset reference input.
// - Reset reference counts only while coarse position is high.
// - Reset reference is used only during the reset procedure.
// - Phase reference pulse every 500 steps checks the step count.
// - Phase changer position counter has no end-stop limits.
// - Five-phase windings are commutated in both directions.
// - Attenuator reference pulse at 60 dB and every 500 steps checks the count.
// - Maximum-limit input inhibits further stepping toward higher attenuation.
// - Minimum-limit input inhibits further stepping toward lower attenuation.
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rvsp_top #(
   parameter int unsigned STEP_PERIOD = rvsp_pkg::STEP_PERIOD_CYC
) (
   // Clock and reset
   input  wire logic              i_ref_clk,
   input  wire logic              i_reset,
   // AXI4-Lite write address and data
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [7:0]        i_awaddr,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   // AXI4-Lite write response
   output logic                   o_bvalid,
   input  wire logic              i_bready,
   output logic [1:0]             o_bresp,
   // AXI4-Lite read
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   input  wire logic [7:0]        i_araddr,
   output logic                   o_rvalid,
   input  wire logic              i_rready,
   output logic [31:0]            o_rdata,
   output logic [1:0]             o_rresp,
   // Instrument sensors (asynchronous)
   input  wire rvsp_pkg::rvsp_sense_t i_sense,
   // Motor windings
   output logic [4:0]             o_winding
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_MOVE,
      ST_HOME_SEEK,
      ST_HOME_FIND
   } rvsp_state_t;

   // ------------------------------------------------------------
   // Sensor synchroniser
   // ------------------------------------------------------------
   rvsp_pkg::rvsp_sense_t sync1_ff;
   rvsp_pkg::rvsp_sense_t sense_ff;
   logic                  ref_prev_ff;
   logic                  ref_rise_w;

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         sync1_ff    <= '0;
         sense_ff    <= '0;
         ref_prev_ff <= 1'b0;
      end else begin
         sync1_ff    <= i_sense;
         sense_ff    <= sync1_ff;
         ref_prev_ff <= sense_ff.pos_ref;
      end
   end

   assign ref_rise_w = sense_ff.pos_ref & ~ref_prev_ff;

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   logic [7:0]  awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic [2:0]  ctrl_ff;
   logic [31:0] setting_ff;
   logic        aw_hs_w;
   logic        w_hs_w;
   logic        do_wr_w;
   logic        wr_ctrl_w;
   logic        wr_set_w;
   logic        wr_stat_w;
   logic        wr_map_w;
   logic        go_w;
   logic        home_w;
   logic [31:0] rd_mux_w;
   logic        rd_map_w;
   logic [31:0] status_w;

   function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   assign aw_hs_w   = i_awvalid & o_awready;
   assign w_hs_w    = i_wvalid & o_wready;
   assign do_wr_w   = ~o_awready & ~o_wready & ~o_bvalid;
   assign wr_ctrl_w = do_wr_w & (awaddr_ff == rvsp_pkg::OFS_CTRL);
   assign wr_set_w  = do_wr_w & (awaddr_ff == rvsp_pkg::OFS_SETTING);
   assign wr_stat_w = do_wr_w & (awaddr_ff == rvsp_pkg::OFS_STATUS) & wstrb_ff[0];
   assign wr_map_w  = (awaddr_ff == rvsp_pkg::OFS_CTRL) | (awaddr_ff == rvsp_pkg::OFS_SETTING)
                    | (awaddr_ff == rvsp_pkg::OFS_STATUS);
   assign go_w      = wr_ctrl_w & wstrb_ff[0] & wdata_ff[rvsp_pkg::CTRL_GO_BIT];
   assign home_w    = wr_ctrl_w & wstrb_ff[0] & wdata_ff[rvsp_pkg::CTRL_HOME_BIT];

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_awready  <= 1'b1;
         o_wready   <= 1'b1;
         o_bvalid   <= 1'b0;
         o_bresp    <= rvsp_pkg::RESP_OKAY;
         awaddr_ff  <= 8'h00;
         wdata_ff   <= 32'h0000_0000;
         wstrb_ff   <= 4'h0;
         ctrl_ff    <= rvsp_pkg::CTRL_RESET;
         setting_ff <= rvsp_pkg::SETTING_RESET;
      end else begin
         if (aw_hs_w) begin
            awaddr_ff <= i_awaddr;
            o_awready <= 1'b0;
         end
         if (w_hs_w) begin
            wdata_ff <= i_wdata;
            wstrb_ff <= i_wstrb;
            o_wready <= 1'b0;
         end
         if (do_wr_w) begin
            o_bvalid <= 1'b1;
            o_bresp  <= wr_map_w ? rvsp_pkg::RESP_OKAY : rvsp_pkg::RESP_SLVERR;
         end else if (o_bvalid & i_bready) begin
            o_bvalid  <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
         end
         if (wr_ctrl_w & wstrb_ff[0]) begin
            ctrl_ff <= wdata_ff[2:0];
         end
         if (wr_set_w) begin
            setting_ff <= apply_strb(setting_ff, wdata_ff, wstrb_ff);
         end
      end
   end

   // ------------------------------------------------------------
   // Target conversion
   // ------------------------------------------------------------
   logic        unit_ph_w;
   logic        steps_mode_w;
   int          set_w;
   int          att_q_w;
   int          att_mdb_w;
   int          seg_w;
   int          frac_w;
   int          bp_lo_w;
   int          bp_hi_w;
   int          att_steps_w;
   int          ph_steps_w;
   logic        over_w;
   logic        bad_steps_w;
   logic        need_home_w;
   logic [31:0] target_w;

   assign unit_ph_w    = ctrl_ff[rvsp_pkg::CTRL_UNIT_BIT];
   assign steps_mode_w = ctrl_ff[rvsp_pkg::CTRL_STEPS_BIT];
   assign set_w        = int'(setting_ff);

   assign att_q_w   = (set_w < rvsp_pkg::ATT_Q1_TOP_MDB) ? rvsp_pkg::ATT_Q1_MDB :
                      (set_w < rvsp_pkg::ATT_Q2_TOP_MDB) ? rvsp_pkg::ATT_Q2_MDB :
                      (set_w < rvsp_pkg::ATT_Q3_TOP_MDB) ? rvsp_pkg::ATT_Q3_MDB :
                      rvsp_pkg::ATT_Q4_MDB;
   assign att_mdb_w = rvsp_pkg::quantise(set_w, att_q_w);

   // Piecewise-linear inverse of the sec law; error is largest near 0 dB
   assign seg_w       = att_mdb_w / rvsp_pkg::ATT_SEG_MDB;
   assign frac_w      = att_mdb_w - seg_w * rvsp_pkg::ATT_SEG_MDB;
   assign bp_lo_w     = rvsp_pkg::att_bp_steps(seg_w);
   assign bp_hi_w     = rvsp_pkg::att_bp_steps(seg_w + 1);
   assign att_steps_w = (seg_w >= rvsp_pkg::ATT_LAST_SEG) ? 0 :
                        bp_lo_w + ((bp_hi_w - bp_lo_w) * frac_w) / rvsp_pkg::ATT_SEG_MDB;
   assign ph_steps_w  = rvsp_pkg::quantise(set_w, rvsp_pkg::PH_MDEG_PER_STEP)
                        / rvsp_pkg::PH_MDEG_PER_STEP;

   assign over_w      = (set_w < 0) | (unit_ph_w ? (att_mdb_w > 0 &&
                        rvsp_pkg::quantise(set_w, rvsp_pkg::PH_MDEG_PER_STEP) > rvsp_pkg::PH_FULL_MDEG)
                        : (att_mdb_w > rvsp_pkg::ATT_FULL_MDB));
   assign bad_steps_w = (set_w < rvsp_pkg::STEPS_MODE_MIN) | (set_w > rvsp_pkg::STEPS_MODE_MAX);
   assign need_home_w = ~steps_mode_w & over_w &
                        (unit_ph_w | ~ctrl_ff[rvsp_pkg::CTRL_HIGHATT_BIT]);
   assign target_w    = steps_mode_w ? setting_ff :
                        (over_w & ~unit_ph_w) ? 32'(rvsp_pkg::MAX_ATTEN_STEPS) :
                        unit_ph_w ? 32'(ph_steps_w) : 32'(att_steps_w);

   // ------------------------------------------------------------
   // Positioning sequencer
   // ------------------------------------------------------------
   rvsp_state_t              st_ff;
   rvsp_state_t              nxt_st;
   logic signed [31:0]       pos_ff;
   logic signed [31:0]       tgt_ff;
   logic [rvsp_pkg::TMR_W-1:0] tmr_ff;
   logic [15:0]              hcnt_ff;
   logic                     refd_ff;
   logic [3:0]               err_ff;
   logic [3:0]               err_set_w;
   logic                     dir_up_w;
   logic                     blocked_w;
   logic                     want_w;
   logic                     step_w;
   logic                     found_w;
   logic                     grid_bad_w;
   logic                     home_to_w;

   assign dir_up_w  = (st_ff == ST_MOVE) ? (tgt_ff > pos_ff) : (st_ff == ST_HOME_FIND);
   // Only the attenuator has limit switches; the phase changer turns freely
   assign blocked_w = ~unit_ph_w & ((dir_up_w & sense_ff.lim_min) |
                                    (~dir_up_w & sense_ff.lim_max));
   assign want_w    = ((st_ff == ST_MOVE) & (pos_ff != tgt_ff) & ~blocked_w)
                    | ((st_ff == ST_HOME_SEEK) & ~sense_ff.lim_max)
                    | ((st_ff == ST_HOME_FIND) & ~found_w & ~home_to_w & ~blocked_w);
   assign step_w    = want_w & (tmr_ff == '0);
   // Reset reference is gated by coarse and looked at only while homing
   assign found_w   = (st_ff == ST_HOME_FIND) & (unit_ph_w ?
                      (sense_ff.coarse & sense_ff.reset_ref) : ref_rise_w);
   assign home_to_w = (hcnt_ff == 16'(rvsp_pkg::HOME_TIMEOUT_STEPS));
   assign grid_bad_w = refd_ff & ref_rise_w & (st_ff != ST_HOME_FIND) &
                       ((pos_ff % rvsp_pkg::REF_INTERVAL_STEPS) != 0);

   assign err_set_w[rvsp_pkg::ERR_RANGE_BIT] = (st_ff == ST_IDLE) & go_w & refd_ff &
                                               steps_mode_w & bad_steps_w;
   assign err_set_w[rvsp_pkg::ERR_REF_BIT]   = grid_bad_w;
   assign err_set_w[rvsp_pkg::ERR_LIMIT_BIT] = (st_ff == ST_MOVE) & (pos_ff != tgt_ff) & blocked_w;
   assign err_set_w[rvsp_pkg::ERR_HOME_BIT]  = (st_ff == ST_HOME_FIND) & home_to_w;

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE: begin
            if (home_w | (go_w & (~refd_ff | need_home_w))) begin
               nxt_st = unit_ph_w ? ST_HOME_FIND : ST_HOME_SEEK;
            end else if (go_w & ~err_set_w[rvsp_pkg::ERR_RANGE_BIT]) begin
               nxt_st = ST_MOVE;
            end
         end
         ST_MOVE: begin
            if ((pos_ff == tgt_ff) | blocked_w) begin
               nxt_st = ST_IDLE;
            end
         end
         ST_HOME_SEEK: begin
            if (sense_ff.lim_max) begin
               nxt_st = ST_HOME_FIND;
            end
         end
         ST_HOME_FIND: begin
            if (found_w | home_to_w | blocked_w) begin
               nxt_st = ST_IDLE;
            end
         end
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         st_ff   <= ST_IDLE;
         pos_ff  <= 32'sh0000_0000;
         tgt_ff  <= 32'sh0000_0000;
         tmr_ff  <= '0;
         hcnt_ff <= 16'h0000;
         refd_ff <= 1'b0;
         err_ff  <= 4'h0;
      end else begin
         st_ff <= nxt_st;
         if ((st_ff == ST_IDLE) & go_w) begin
            tgt_ff <= target_w;
         end
         if (step_w) begin
            tmr_ff <= rvsp_pkg::TMR_W'(STEP_PERIOD - 1);
         end else if (tmr_ff != '0) begin
            tmr_ff <= tmr_ff - 1'b1;
         end
         if (found_w) begin
            pos_ff  <= 32'sh0000_0000;
            refd_ff <= 1'b1;
         end else if (step_w) begin
            pos_ff <= dir_up_w ? pos_ff + 32'sh0000_0001 : pos_ff - 32'sh0000_0001;
         end
         if (nxt_st == ST_HOME_SEEK || nxt_st == ST_HOME_FIND) begin
            if (st_ff == ST_IDLE) begin
               refd_ff <= 1'b0;
            end
         end
         if (st_ff != ST_HOME_FIND) begin
            hcnt_ff <= 16'h0000;
         end else if (step_w) begin
            hcnt_ff <= hcnt_ff + 16'h0001;
         end
         // A new error in the clearing cycle is kept
         err_ff <= (err_ff & ~(wr_stat_w ? wdata_ff[rvsp_pkg::STAT_ERR_LSB +: 4] : 4'h0))
                   | err_set_w;
      end
   end

   rvsp_phase_seq u_seq (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .i_step    (step_w),
      .i_dir_up  (dir_up_w),
      .o_winding (o_winding)
   );

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   assign status_w = {24'h00_0000, err_ff, sense_ff.lim_min, sense_ff.lim_max, refd_ff,
                      (st_ff != ST_IDLE)};
   assign rd_map_w = (i_araddr == rvsp_pkg::OFS_CTRL) | (i_araddr == rvsp_pkg::OFS_SETTING)
                   | (i_araddr == rvsp_pkg::OFS_STATUS) | (i_araddr == rvsp_pkg::OFS_POS)
                   | (i_araddr == rvsp_pkg::OFS_TARGET);
   assign rd_mux_w = (i_araddr == rvsp_pkg::OFS_CTRL)    ? {29'h0000_0000, ctrl_ff} :
                     (i_araddr == rvsp_pkg::OFS_SETTING) ? setting_ff :
                     (i_araddr == rvsp_pkg::OFS_STATUS)  ? status_w :
                     (i_araddr == rvsp_pkg::OFS_POS)     ? pos_ff :
                     (i_araddr == rvsp_pkg::OFS_TARGET)  ? tgt_ff : 32'h0000_0000;

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h0000_0000;
         o_rresp   <= rvsp_pkg::RESP_OKAY;
      end else if (i_arvalid & o_arready) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b1;
         o_rdata   <= rd_mux_w;
         o_rresp   <= rd_map_w ? rvsp_pkg::RESP_OKAY : rvsp_pkg::RESP_SLVERR;
      end else if (o_rvalid & i_rready) begin
         o_rvalid  <= 1'b0;
         o_arready <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// File: include/rvsp_pkg.sv
package rvsp_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ           = 250_000_000;
   localparam int unsigned STEP_RATE_MAX_HZ = 8500;
   // Least step spacing, rounded up so the rate never exceeds the limit
   localparam int unsigned STEP_PERIOD_CYC  = (CLK_HZ + STEP_RATE_MAX_HZ - 1) / STEP_RATE_MAX_HZ;
   localparam int unsigned TMR_W            = 16;

   // ------------------------------------------------------------
   // Register map (byte addresses) and field positions
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_SETTING = 8'h04;
   localparam logic [7:0] OFS_STATUS  = 8'h08;
   localparam logic [7:0] OFS_POS     = 8'h0C;
   localparam logic [7:0] OFS_TARGET  = 8'h10;

   localparam int CTRL_UNIT_BIT    = 0;
   localparam int CTRL_STEPS_BIT   = 1;
   localparam int CTRL_HIGHATT_BIT = 2;
   localparam int CTRL_GO_BIT      = 3;
   localparam int CTRL_HOME_BIT    = 4;

   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_REFD_BIT  = 1;
   localparam int STAT_LMAX_BIT  = 2;
   localparam int STAT_LMIN_BIT  = 3;
   localparam int STAT_ERR_LSB   = 4;
   localparam int ERR_RANGE_BIT  = 0;
   localparam int ERR_REF_BIT    = 1;
   localparam int ERR_LIMIT_BIT  = 2;
   localparam int ERR_HOME_BIT   = 3;

   localparam logic [2:0]  CTRL_RESET    = 3'h0;
   localparam logic [31:0] SETTING_RESET = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // ------------------------------------------------------------
   // Position law and ranges
   // ------------------------------------------------------------
   localparam int ATT_ZERO_DB_STEPS  = 8574;
   localparam int STEPS_MODE_MIN     = -150;
   localparam int STEPS_MODE_MAX     = 8574;
   localparam int MAX_ATTEN_STEPS    = -145;
   localparam int ATT_FULL_MDB       = 60000;
   localparam int ATT_SEG_MDB        = 4000;
   localparam int ATT_LAST_SEG       = 15;
   localparam int ATT_Q1_TOP_MDB     = 21000;
   localparam int ATT_Q2_TOP_MDB     = 30000;
   localparam int ATT_Q3_TOP_MDB     = 48000;
   localparam int ATT_Q1_MDB         = 10;
   localparam int ATT_Q2_MDB         = 20;
   localparam int ATT_Q3_MDB         = 50;
   localparam int ATT_Q4_MDB         = 100;
   localparam int PH_FULL_MDEG       = 720000;
   localparam int PH_MDEG_PER_STEP   = 200;
   localparam int REF_INTERVAL_STEPS = 500;
   localparam int HOME_TIMEOUT_STEPS = 20000;
   localparam int WINDING_PHASES     = 5;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic coarse;
      logic reset_ref;
      logic pos_ref;
      logic lim_max;
      logic lim_min;
   } rvsp_sense_t;

   // Steps from reference at 0, 4, 8 ... 60 dB, sec-law breakpoints
   function automatic int att_bp_steps(input int idx);
      case (idx)
         0:       return 8574;
         1:       return 4935;
         2:       return 3627;
         3:       return 2748;
         4:       return 2105;
         5:       return 1616;
         6:       return 1239;
         7:       return 943;
         8:       return 711;
         9:       return 527;
         10:      return 382;
         11:      return 267;
         12:      return 176;
         13:      return 103;
         14:      return 46;
         default: return 0;
      endcase
   endfunction

   // Round to the nearest multiple of the quantum
   function automatic int quantise(input int v, input int q);
      return ((v + q / 2) / q) * q;
   endfunction

endpackage

// File: hw/rvsp_phase_seq.sv
`timescale 1ns/1ps
`default_nettype none
module rvsp_phase_seq #(
   parameter int SEQ_LEN = 10
) (
   // Clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset,
   // Step request
   input  wire logic       i_step,
   input  wire logic       i_dir_up,
   // Windings
   output logic [4:0]      o_winding
);

   logic [3:0] idx_ff;
   logic [3:0] nxt_idx;

   // Alternates two and three energised windings around the five phases
   function automatic logic [4:0] pattern(input logic [3:0] i);
      logic [9:0] two;
      logic [9:0] three;
      logic [4:0] base;
      two   = 10'h063 << i[3:1];
      three = 10'h0E7 << i[3:1];
      base  = i[0] ? (three[4:0] | three[9:5]) : (two[4:0] | two[9:5]);
      return base & 5'h1F;
   endfunction

   assign nxt_idx = !i_step ? idx_ff :
                    i_dir_up ? ((idx_ff == 4'(SEQ_LEN - 1)) ? 4'h0 : idx_ff + 4'h1) :
                    ((idx_ff == 4'h0) ? 4'(SEQ_LEN - 1) : idx_ff - 4'h1);

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         idx_ff    <= 4'h0;
         o_winding <= 5'h03;
      end else begin
         idx_ff    <= nxt_idx;
         o_winding <= pattern(nxt_idx);
      end
   end

endmodule
`default_nettype wire

// File: verif/rvsp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rvsp_chk #(
   parameter int unsigned STEP_PERIOD = 8
) (
   // Clock and reset
   input wire logic        i_ref_clk,
   input wire logic        i_reset,
   // Bus handshakes
   input wire logic        i_awvalid,
   input wire logic        o_awready,
   input wire logic        o_bvalid,
   input wire logic        i_bready,
   input wire logic        i_arvalid,
   input wire logic        o_arready,
   input wire logic        o_rvalid,
   input wire logic        i_rready,
   input wire logic [31:0] o_rdata,
   // Windings
   input wire logic [4:0]  o_winding
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   localparam int SP = STEP_PERIOD;
   // Starts full so the first step after reset is legal
   int         gap_ff;
   int         nxt_gap;
   logic [4:0] wind_ff;
   assign nxt_gap = (o_winding != wind_ff) ? 0 : ((gap_ff < SP) ? gap_ff + 1 : gap_ff);
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         gap_ff  <= SP;
         wind_ff <= 5'h03;
      end else begin
         gap_ff  <= nxt_gap;
         wind_ff <= o_winding;
      end
   end
   sequence s_aw_take;
      i_awvalid && o_awready;
   endsequence
   chk_step_gap: assert property ((o_winding != wind_ff) |-> gap_ff >= SP - 1)
      else $error("winding stepped too soon");
   chk_wind_count: assert property ($countones(o_winding) inside {2, 3})
      else $error("winding pattern not two or three phases");
   chk_b_answer: assert property (s_aw_take |-> ##2 o_bvalid)
      else $error("write response late");
   chk_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
      else $error("write response dropped");
   chk_r_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read data late");
   chk_r_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped or changed");
   chk_ar_block: assert property (o_rvalid |-> !o_arready)
      else $error("read address taken while data pending");
   chk_aw_block: assert property (o_bvalid |-> !o_awready)
      else $error("write address taken while response pending");
endmodule
`default_nettype wire

// File: verif/rvsp_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module rvsp_motor_model (
   // Clock and windings
   input  wire logic           i_ref_clk,
   input  wire logic [4:0]     i_winding,
   // Sensor lines
   output var rvsp_pkg::rvsp_sense_t o_sense
);
   // Commutation order; the neighbour that follows gives the direction of travel
   localparam logic [4:0] SEQ [10] = '{5'h03, 5'h07, 5'h06, 5'h0E, 5'h0C, 5'h1C, 5'h18, 5'h19,
                                       5'h11, 5'h13};
   int mech = 20;
   int idx  = 0;
   // Non-blocking so the sensor lines never race the design's input flops
   always @(posedge i_ref_clk) begin
      if (i_winding === SEQ[(idx + 1) % 10]) begin
         idx  <= (idx + 1) % 10;
         mech <= mech + 1;
      end else if (i_winding === SEQ[(idx + 9) % 10]) begin
         idx  <= (idx + 9) % 10;
         mech <= mech - 1;
      end
   end
   assign o_sense = '{coarse: mech inside {[60:69]}, reset_ref: mech inside {[60:66]},
                      pos_ref: (mech % 500 == 0),
                      lim_max: (mech <= -220),
                      lim_min: (mech >= 8774)};
endmodule
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int unsigned STEP_PERIOD = 8;
   logic        i_ref_clk = 1'b0;
   logic        i_reset   = 1'b1;
   logic        i_awvalid = 1'b0;
   logic        i_wvalid  = 1'b0;
   logic        i_bready  = 1'b0;
   logic        i_arvalid = 1'b0;
   logic        i_rready  = 1'b0;
   logic [7:0]  i_awaddr  = 8'h00;
   logic [7:0]  i_araddr  = 8'h00;
   logic [31:0] i_wdata   = 32'h0000_0000;
   logic [3:0]  i_wstrb   = 4'hF;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0]  o_bresp, o_rresp, rsp;
   logic [31:0] o_rdata, rd_v;
   logic [4:0]  o_winding;
   rvsp_pkg::rvsp_sense_t i_sense;
   int          mismatches = 0;
   int          checked    = 0;
   int          cyc        = 0;
   // Steps range and moves, 60 dB, over range with high attenuation on and off, phase
   logic [31:0] set_v [9]  = '{32'hFFFF_FF69, 32'h0000_217F, 32'h0000_0005, 32'hFFFF_FF6A,
                               32'h0000_EA60, 32'h0000_EE48, 32'h0000_EE48, 32'h0000_044B,
                               32'h0000_044B};
   logic [7:0]  ctl_v [9]  = '{8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h08, 8'h0C, 8'h08, 8'h09, 8'h11};
   logic [31:0] pos_v [9]  = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0005, 32'hFFFF_FF6A,
                               32'h0000_0000, 32'(rvsp_pkg::MAX_ATTEN_STEPS), 32'h0000_0000,
                               32'h0000_0005, 32'h0000_0000};
   logic        err_v [9]  = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
   rvsp_top #(.STEP_PERIOD(STEP_PERIOD)) u_dut (.i_ref_clk, .i_reset, .i_awvalid, .o_awready,
      .i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp,
      .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_sense,
      .o_winding);
   rvsp_motor_model u_motor (.i_ref_clk, .i_winding(o_winding), .o_sense(i_sense));
   initial begin
      forever #2 i_ref_clk = ~i_ref_clk;
   end
   // -----------------------------------------------------------
   // Bus tasks
   // -----------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_awvalid <= 1'b1;
      i_awaddr  <= a;
      i_wvalid  <= 1'b1;
      i_wdata   <= d;
      i_bready  <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         if (i_awvalid && o_awready) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      end while (!o_bvalid);
      i_bready <= 1'b0;
      rsp = o_bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_ref_clk);
      i_arvalid <= 1'b1;
      i_araddr  <= a;
      i_rready  <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      end while (!o_rvalid);
      i_rready <= 1'b0;
      rd_v = o_rdata;
      rsp = o_rresp;
   endtask
   task automatic wait_idle;
      do rd(8'h08); while (rd_v[0] !== 1'b0);
   endtask
   task automatic end_of_test;
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Homing plus the moves should stay well under this ceiling
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         end_of_test();
      end
   end
   initial begin
      repeat (2) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      rd(8'h08);
      chk("status reset", 32'h0000_0000, rd_v);
      rd(8'h14);
      chk("unmapped resp", 32'h0000_0002, {30'h0000_0000, rsp});
      wr(8'h0C, 32'h0000_0007);
      chk("position write resp", 32'h0000_0002, {30'h0000_0000, rsp});
      wr(8'h00, 32'h0000_0008);
      wait_idle();
      chk("referenced", 32'h0000_0002, rd_v & 32'h0000_0003);
      rd(8'h0C);
      chk("home position", 32'h0000_0000, rd_v);
      for (int i = 0; i < 9; i++) begin
         // Mode first: GO and HOME act on the mode already held
         wr(8'h00, {29'h0000_0000, ctl_v[i][2:0]});
         wr(8'h04, set_v[i]);
         wr(8'h00, {24'h00_0000, ctl_v[i]});
         wait_idle();
         chk("error flags", {31'h0000_0000, err_v[i]}, {28'h000_0000, rd_v[7:4]});
         rd(8'h0C);
         chk("position", pos_v[i], rd_v);
         wr(8'h08, 32'h0000_00F0);
      end
      end_of_test();
   end
endmodule
bind rvsp_top rvsp_chk #(.STEP_PERIOD(STEP_PERIOD)) u_chk (.i_ref_clk, .i_reset, .i_awvalid,
   .o_awready, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rvalid, .i_rready, .o_rdata,
   .o_winding);
`default_nettype wire
